// >>> rf_mod_timing.sv
`timescale 1ns/100ps
`default_nettype none
`include "rf_mod_timing_params.svh"
module rf_mod_timing (
  // clock, reset, enable
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic clk_en,
  // internal register port
  input wire logic [5:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  // driver state and on-state codes
  input wire logic driver_on,
  input wire logic soft_power_down,
  input wire logic [3:0] on_unmodulated_n_conductance,
  input wire logic [3:0] on_modulated_n_conductance,
  input wire logic modulate,
  input wire logic load_modulation_a,
  // carrier timing and mode strobes
  input wire logic fc_tick,
  input wire logic miller_start,
  input wire logic subcarrier_en,
  input wire logic tx_request,
  // outputs to driver and framing
  output logic [3:0] n_conductance,
  output logic [14:0] n_segment_en,
  output logic miller_pulse,
  output logic subcarrier,
  output logic tx_go,
  output logic demod_clock_from_field
);

  // ==========================================================
  // registers
  // ==========================================================
  logic [7:0] driver_off_n_conductance_r; // off-state codes
  logic [7:0] modulation_width_r; // pulse_width_value
  logic [7:0] transmit_bit_phase_r; // source bit and delay

  // address decode, shared by write and read paths
  function automatic logic hit(input logic [5:0] a, input logic [5:0] r);
    hit = (a == r);
  endfunction

  wire logic wr_off = reg_wr & hit(reg_addr, `ADDR_DRIVER_OFF_N);
  wire logic wr_wid = reg_wr & hit(reg_addr, `ADDR_MOD_WIDTH);
  wire logic wr_pha = reg_wr & hit(reg_addr, `ADDR_TX_BIT_PHASE);

  // read mux; unmapped addresses read zero
  wire logic [7:0] rd_mux =
    hit(reg_addr, `ADDR_DRIVER_OFF_N) ? driver_off_n_conductance_r :
    hit(reg_addr, `ADDR_MOD_WIDTH) ? modulation_width_r :
    hit(reg_addr, `ADDR_TX_BIT_PHASE) ? transmit_bit_phase_r : 8'h00;

  // register writes and registered read data
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      driver_off_n_conductance_r <= `RST_DRIVER_OFF_N;
      modulation_width_r <= `RST_MOD_WIDTH;
      transmit_bit_phase_r <= `RST_TX_BIT_PHASE;
      reg_rdata <= 8'h00;
    end else if (clk_en) begin
      if (wr_off) begin
        driver_off_n_conductance_r <= reg_wdata;
      end
      if (wr_wid) begin
        modulation_width_r <= reg_wdata;
      end
      if (wr_pha) begin
        transmit_bit_phase_r <= reg_wdata;
      end
      if (reg_rd) begin
        reg_rdata <= rd_mux;
      end
    end
  end

  // ==========================================================
  // conductance selection
  // ==========================================================
  rf_mod_timing_pkg::cond_pair_s off_pair; // driver-off codes
  rf_mod_timing_pkg::cond_pair_s on_pair; // driver-on codes
  rf_mod_timing_pkg::cond_pair_s use_pair; // chosen pair

  // one assignment per pair, unmodulated code in the upper half
  assign off_pair = {
    driver_off_n_conductance_r[`UNMOD_HI:`UNMOD_LO],
    driver_off_n_conductance_r[`MODC_HI:`MODC_LO]};
  assign on_pair = {on_unmodulated_n_conductance, on_modulated_n_conductance};

  // load modulation drives the off-state codes even with the
  // driver on, so the answer to a reader keeps its own index
  wire logic use_off = ~driver_on | load_modulation_a;
  assign use_pair = use_off ? off_pair : on_pair;
  wire logic in_mod = modulate | load_modulation_a;
  wire logic [3:0] raw_code = in_mod ? use_pair.modul : use_pair.unmod;

  // power-down override on the top bit of whichever code is used
  wire logic [3:0] forced_code = {raw_code[`CODE_MSB] | soft_power_down,
                                  raw_code[`CODE_MSB-1:0]};

  // registered code so the driver never sees mux glitches
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      n_conductance <= 4'h0;
    end else if (clk_en) begin
      n_conductance <= forced_code;
    end
  end

  // bit i enables 2**i unit segments: binary weighting
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_seg
      assign n_segment_en[(2**gi)*2-2:(2**gi)-1] =
        {(2**gi){n_conductance[gi]}};
    end
  endgenerate

  // ==========================================================
  // miller pulse, initiator side
  // ==========================================================
  logic [8:0] miller_cnt_r; // carrier cycles left in pulse

  // width sampled only at pulse start; a mid-pulse write
  // waits for the next pulse and cannot truncate this one
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      miller_cnt_r <= 9'h000;
    end else if (clk_en) begin
      if (miller_start) begin
        miller_cnt_r <= {1'b0, modulation_width_r} + `MILLER_ADD;
      end else if (fc_tick && miller_cnt_r != 9'h000) begin
        miller_cnt_r <= miller_cnt_r - `MILLER_ADD;
      end
    end
  end
  // host keeps the width under half a bit; no clamp here
  assign miller_pulse = (miller_cnt_r != 9'h000);

  // ==========================================================
  // subcarrier duty cycle, target and card side
  // ==========================================================
  logic [3:0] sub_cnt_r; // position within 16-cycle period
  logic [3:0] sub_low_r; // low-phase length this period
  logic subcarrier_r;
  wire logic [3:0] low_len = {1'b0,
    modulation_width_r[`SUB_WIDTH_HI:`SUB_WIDTH_LO] & `SUB_MOD_MASK}
    + `SUB_LOW_ADD;

  // period counter; low length reloaded at each period start
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      sub_cnt_r <= 4'h0;
      // shortest legal low phase until the first reload
      sub_low_r <= `SUB_LOW_ADD;
    end else if (clk_en) begin
      if (!subcarrier_en) begin
        sub_cnt_r <= 4'h0;
        sub_low_r <= low_len;
      end else if (fc_tick) begin
        sub_cnt_r <= sub_cnt_r + 4'h1;
        if (sub_cnt_r == `SUB_PERIOD_LAST) begin
          sub_low_r <= low_len;
        end
      end
    end
  end

  // low for the first sub_low_r cycles, high the remainder
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      subcarrier_r <= 1'b0;
    end else if (clk_en) begin
      subcarrier_r <= subcarrier_en & (sub_cnt_r >= sub_low_r);
    end
  end
  assign subcarrier = subcarrier_r;

  // ==========================================================
  // transmit start delay
  // ==========================================================
  rf_mod_timing_pkg::tx_state_e tx_state_r;
  logic [6:0] tx_cnt_r; // carrier cycles still to wait
  logic tx_go_r;

  // host sets the delay for bit alignment
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      tx_state_r <= rf_mod_timing_pkg::TX_IDLE;
      tx_cnt_r <= 7'h00;
      tx_go_r <= 1'b0;
    end else if (clk_en) begin
      tx_go_r <= 1'b0;
      case (tx_state_r)
        rf_mod_timing_pkg::TX_IDLE: begin
          if (tx_request) begin
            // delay captured once per frame
            tx_cnt_r <= transmit_bit_phase_r[`PHASE_HI:`PHASE_LO];
            tx_state_r <= rf_mod_timing_pkg::TX_WAIT;
          end
        end
        rf_mod_timing_pkg::TX_WAIT: begin
          if (tx_cnt_r == 7'h00) begin
            tx_go_r <= 1'b1;
            tx_state_r <= rf_mod_timing_pkg::TX_IDLE;
          end else if (fc_tick) begin
            tx_cnt_r <= tx_cnt_r - 7'h01;
          end
        end
        default: begin
          tx_state_r <= rf_mod_timing_pkg::TX_IDLE;
        end
      endcase
    end
  end
  assign tx_go = tx_go_r;

  // demodulator clock source select
  assign demod_clock_from_field =
    transmit_bit_phase_r[`DEMOD_SRC_BIT];

endmodule
`default_nettype wire

// >>> rf_mod_timing_params.svh
`ifndef RF_MOD_TIMING_PARAMS_SVH
`define RF_MOD_TIMING_PARAMS_SVH
// register addresses on the internal register port
`define ADDR_DRIVER_OFF_N 6'h23
`define ADDR_MOD_WIDTH 6'h24
`define ADDR_TX_BIT_PHASE 6'h25
// reset values
`define RST_DRIVER_OFF_N 8'h88
`define RST_MOD_WIDTH 8'h26
`define RST_TX_BIT_PHASE 8'h87
// field positions
`define UNMOD_HI 7
`define UNMOD_LO 4
`define MODC_HI 3
`define MODC_LO 0
`define DEMOD_SRC_BIT 7
`define PHASE_HI 6
`define PHASE_LO 0
`define CODE_MSB 3
// subcarrier and miller timing in carrier cycles
`define SUB_PERIOD_LAST 4'hf
`define SUB_MOD_MASK 3'h7
`define SUB_LOW_ADD 4'h1
`define SUB_WIDTH_HI 2
`define SUB_WIDTH_LO 0
`define MILLER_ADD 9'h001
`endif

// >>> rf_mod_timing_pkg.sv
package rf_mod_timing_pkg;
  // pair of conductance codes for one driver state
  typedef struct packed {
    logic [3:0] unmod;
    logic [3:0] modul;
  } cond_pair_s;
  // transmit start delay sequencer
  typedef enum logic [0:0] {TX_IDLE, TX_WAIT} tx_state_e;
endpackage

// >>> rf_mod_timing_properties.sv
`timescale 1ns/100ps
`default_nettype none
// ======================================
// port checks for the modulation timing block
module rf_mod_timing_properties (
  // clock and control
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic clk_en,
  // register port
  input wire logic [5:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  // driver codes and timing
  input wire logic soft_power_down,
  input wire logic [3:0] n_conductance,
  input wire logic [14:0] n_segment_en,
  input wire logic fc_tick,
  input wire logic miller_start,
  input wire logic miller_pulse,
  input wire logic subcarrier_en,
  input wire logic subcarrier,
  input wire logic tx_go,
  input wire logic demod_clock_from_field
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!resetn);
  // the three mapped registers
  wire mapped = reg_addr inside {6'h23, 6'h24, 6'h25};
  // write then read of the same place
  sequence wr_s; clk_en && reg_wr && mapped; endsequence
  sequence rd_s; clk_en && reg_rd && !reg_wr && reg_addr == $past(reg_addr);
  endsequence
  seg_weight_a: assert property (
    n_segment_en == {{8{n_conductance[3]}}, {4{n_conductance[2]}},
    {2{n_conductance[1]}}, n_conductance[0]}) else $error("segment map");
  pd_force_a: assert property (
    clk_en && soft_power_down |=> n_conductance[3]) else $error("pd msb");
  demod_src_a: assert property (
    clk_en && reg_wr && reg_addr == 6'h25
    |=> demod_clock_from_field == $past(reg_wdata[7])) else $error("demod");
  read_back_a: assert property (
    wr_s ##1 rd_s |=> reg_rdata == $past(reg_wdata, 2)) else $error("rdback");
  miller_rise_a: assert property (
    clk_en && miller_start |=> miller_pulse) else $error("miller rise");
  miller_drop_a: assert property (
    $fell(miller_pulse) |-> $past(fc_tick) && $past(clk_en))
    else $error("miller drop");
  sub_idle_a: assert property (
    clk_en && !subcarrier_en |=> !subcarrier) else $error("sub idle");
  tx_pulse_a: assert property (
    clk_en && tx_go |=> !tx_go) else $error("tx pulse");
endmodule
bind rf_mod_timing rf_mod_timing_properties i_props (.*);
`default_nettype wire

// >>> rf_field_model.sv
`timescale 1ns/100ps
`default_nettype none
// ======================================
// rf field: carrier strobes out, driver sink strength back
module rf_field_model (
  // carrier
  input wire logic core_clk,
  input wire logic fast,
  output logic fc_tick,
  // antenna driver load
  input wire logic [14:0] n_segment_en,
  output logic [3:0] strength
);
  logic ph_r = 1'b0; // carrier phase
  always_ff @(posedge core_clk) ph_r <= !ph_r;
  // fast mode makes one carrier cycle per core cycle
  assign fc_tick = fast | ph_r;
  // each unit segment sinks one unit of current
  always_comb begin
    strength = 4'h0;
    for (int i = 0; i < 15; i++) strength += {3'h0, n_segment_en[i]};
  end
endmodule
`default_nettype wire

// >>> testbench.sv
`timescale 1ns/100ps
`default_nettype none
// ======================================
// self-checking bench, notes queued by driver
module testbench;
  logic core_clk = 1'b0, resetn = 1'b0, clk_en = 1'b1, fast = 1'b0;
  logic reg_wr = 1'b0, reg_rd = 1'b0, driver_on = 1'b0, modulate = 1'b0;
  logic soft_power_down = 1'b0, load_modulation_a = 1'b0, sub_win = 1'b0;
  logic miller_start = 1'b0, subcarrier_en = 1'b0, tx_request = 1'b0;
  logic [5:0] reg_addr = 6'h00;
  logic [7:0] reg_wdata = 8'h00, mcnt = 8'h00, exp_q[$];
  logic [3:0] on_unmodulated_n_conductance = 4'h0, strength;
  logic [3:0] on_modulated_n_conductance = 4'h0, n_conductance;
  logic [7:0] reg_rdata;
  logic [14:0] n_segment_en;
  logic fc_tick, miller_pulse, subcarrier, tx_go, demod_clock_from_field;
  logic [1:0] what = 2'h0; // which output the next note is about
  logic [16:0] lf = 17'h1185b;
  int err_count = 0, compares = 0;
  event chk_ev;
  wire [7:0] obs = what == 2'h0 ? reg_rdata : what == 2'h1 ?
    {4'h0, n_conductance} : what == 2'h2 ? mcnt :
    {3'h0, demod_clock_from_field, strength};
  rf_mod_timing i_rf_mod_timing (.*);
  rf_field_model i_rf_field_model (.*);
  always #4 core_clk = !core_clk;
  // carrier ticks seen while a pulse or gated subcarrier is high
  always @(posedge core_clk)
    if (fc_tick && (miller_pulse || (subcarrier && sub_win)))
      mcnt <= mcnt + 8'h01;
  // watcher: oldest note against settled outputs
  always @(chk_ev) begin
    #3;
    check(obs, exp_q.pop_front());
  end
  function automatic logic [16:0] lfsr(input logic [16:0] v);
    return {v[15:0], v[16] ^ v[13]};
  endfunction
  task check(input logic [7:0] seen, input logic [7:0] want);
    compares++;
    if (seen !== want) begin
      err_count++;
      $display("MISMATCH %0t seen %h want %h", $time, seen, want);
    end
  endtask
  task tick; @(posedge core_clk) #1; endtask
  task note(input logic [1:0] w, input logic [7:0] e);
    what = w;
    exp_q.push_back(e);
    -> chk_ev;
    tick;
  endtask
  // one-edge write; caller must not start another in the same step
  task wr(input logic [5:0] a, input logic [7:0] d);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    tick;
    reg_wr = 1'b0;
  endtask
  task rd(input logic [5:0] a, input logic [7:0] e);
    reg_addr = a;
    reg_rd = 1'b1;
    tick;
    reg_rd = 1'b0;
    note(2'h0, e);
  endtask
  task summarize;
    $display("compares %0d err_count %0d", compares, err_count);
    if (err_count == 0 && compares > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // ======================================
  // main sequence
  initial begin
    logic [3:0] c;
    logic [7:0] w;
    int n, base;
    repeat (12) tick;
    resetn = 1'b1;
    rd(6'h23, 8'h88);
    rd(6'h24, 8'h26);
    rd(6'h25, 8'h87);
    rd(6'h26, 8'h00);
    lf = lfsr(lf);
    wr(6'h23, lf[7:0]);
    rd(6'h23, lf[7:0]);
    on_unmodulated_n_conductance = lf[11:8];
    on_modulated_n_conductance = lf[15:12];
    // every driver state, modulation, load and power-down mix
    for (int i = 0; i < 16; i++) begin
      {soft_power_down, load_modulation_a, modulate, driver_on} = i[3:0];
      tick;
      c = (!driver_on || load_modulation_a) ?
        (i[1] || i[2] ? lf[3:0] : lf[7:4]) :
        (modulate ? lf[15:12] : lf[11:8]);
      c[3] = c[3] | soft_power_down;
      note(2'h1, {4'h0, c});
      // demod source still at its reset setting here
      note(2'h3, {4'h1, c});
    end
    // miller pulse, width rewritten mid-pulse
    for (int k = 0; k < 2; k++) begin
      lf = lfsr(lf);
      w = k ? {2'h0, lf[5:0]} : 8'h00;
      wr(6'h24, w);
      mcnt = 8'h00;
      miller_start = 1'b1;
      tick;
      miller_start = 1'b0;
      wr(6'h24, ~w);
      for (n = 0; n < 300 && miller_pulse; n++) tick;
      // a pulse that never ends is a failure of its own
      if (n == 300) err_count++;
      note(2'h2, w + 8'h01);
    end
    // subcarrier duty over two whole periods
    lf = lfsr(lf);
    wr(6'h24, lf[7:0]);
    subcarrier_en = 1'b1;
    repeat (40) tick;
    mcnt = 8'h00;
    sub_win = 1'b1;
    repeat (64) tick;
    sub_win = 1'b0;
    note(2'h2, 8'h1e - {4'h0, lf[2:0], 1'b0});
    subcarrier_en = 1'b0;
    fast = 1'b1;
    // a write with the clock enable low must leave no trace
    clk_en = 1'b0;
    wr(6'h24, ~lf[7:0]);
    clk_en = 1'b1;
    rd(6'h24, lf[7:0]);
    // send delay relative to a zero setting
    for (int k = 0; k < 2; k++) begin
      lf = lfsr(lf);
      w = k ? {1'b0, lf[6:0]} : 8'h00;
      wr(6'h25, w);
      tx_request = 1'b1;
      tick;
      tx_request = 1'b0;
      for (n = 0; n < 300 && !tx_go; n++) tick;
      if (n == 300) err_count++;
      if (k == 0) base = n;
      else mcnt = 8'(n - base);
    end
    note(2'h2, w);
    summarize;
  end
  // watchdog well beyond the few hundred cycles needed
  initial begin
    #200000;
    err_count++;
    summarize;
  end
endmodule
`default_nettype wire
